// file: logic/dcd_decoder.sv
`timescale 1ns/1ns
`default_nettype none
`include "dcd_cfg.svh"
module dcd_decoder (
  input  wire logic                   i_clk,
  input  wire logic                   i_srst,
  input  wire logic                   i_scl,
  input  wire logic                   i_sda,
  output logic                        o_sda_o,
  output logic                        o_sda_oe,
  input  wire logic [2:0]             i_addr_sel,
  input  wire logic                   i_fmt_8bit,
  input  wire logic                   i_nvm_idle_flag,
  input  wire logic [11:0]            i_nvm_dac,
  input  wire logic [4:0]             i_nvm_cfg,
  output logic [11:0]                 o_dac_value,
  output logic [1:0]                  o_vref_sel,
  output logic [1:0]                  o_powerdown_select_bits,
  output logic                        o_gain_sel,
  output logic                        o_reload_pulse,
  output logic                        o_nvm_wr_valid,
  input  wire logic                   i_nvm_wr_ready,
  output logic [`DCD_NVM_W-1:0]       o_nvm_wr_data
);
  dcd_pkg::dcd_state_e state_reg;
  dcd_pkg::dcd_op_e    op_reg;
  dcd_pkg::dcd_op_e    byte_op;
  logic                scl_q;
  logic                sda_q;
  logic                start_det;
  logic                stop_det;
  logic                scl_rise;
  logic                scl_fall;
  logic                byte_end;
  logic                ack_end;
  logic [3:0]          bit_cnt_reg;
  logic [7:0]          shift_reg;
  logic [1:0]          byte_idx_reg;
  logic [7:0]          b0_reg;
  logic [7:0]          b1_reg;
  logic [7:0]          b2_reg;
  logic                commit_pend_reg;
  logic                commit;
  logic                gc_done_reg;
  logic                byte_ack;
  logic                byte_last;
  logic                addr_match;
  logic                nvm_busy;
  logic                drive_reg;
  logic [7:0]          tx_reg;
  logic [7:0]          tx_byte;
  logic [2:0]          rd_idx_reg;
  logic [2:0]          rd_last;
  logic [11:0]         dac_reg;
  logic [4:0]          cfg_reg;
  logic                por_load_reg;
  logic [11:0]         dac_cmd_word;
  logic [11:0]         vol_cmd_word;

  dcd_stream_if #(.W(`DCD_NVM_W)) push_if ();
  dcd_stream_if #(.W(`DCD_NVM_W)) pop_if ();

  function automatic dcd_pkg::dcd_op_e decode_op(input logic [2:0] code);
    dcd_pkg::dcd_op_e op;
    op = dcd_pkg::OP_NONE;
    if (code[2:1] == `DCD_CMD_DAC_HI)
    begin
      op = dcd_pkg::OP_DAC;
    end
    else if (code == `DCD_CMD_VOL)
    begin
      op = dcd_pkg::OP_VOL;
    end
    else if (code == `DCD_CMD_ALL)
    begin
      op = dcd_pkg::OP_ALL;
    end
    else if (code == `DCD_CMD_CFG)
    begin
      op = dcd_pkg::OP_CFG;
    end
    return op;
  endfunction

  // Bus condition detection
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end
    else
    begin
      scl_q <= i_scl;
      sda_q <= i_sda;
    end
  end

  assign start_det    = scl_q && i_scl && sda_q && !i_sda;
  assign stop_det     = scl_q && i_scl && !sda_q && i_sda;
  assign scl_rise     = !scl_q && i_scl;
  assign scl_fall     = scl_q && !i_scl;
  assign byte_end     = scl_fall && (bit_cnt_reg == `DCD_BIT_BYTE);
  assign ack_end      = scl_fall && (bit_cnt_reg == `DCD_BIT_ACK);
  assign commit       = ack_end && commit_pend_reg;
  assign addr_match   = (shift_reg[7:1] == {`DCD_ADDR_PREFIX, i_addr_sel});
  assign nvm_busy     = !i_nvm_idle_flag;
  assign dac_cmd_word = {b0_reg[`DCD_B0_DACHI], b1_reg};
  assign vol_cmd_word = {b1_reg, b2_reg[`DCD_B2_DACLO]};
  assign rd_last      = i_fmt_8bit ? `DCD_RD_LAST8 : `DCD_RD_LAST12;

  // Bit slot counter and receive shifter
  always_ff @(posedge i_clk)
  begin
    if (i_srst || start_det || stop_det)
    begin
      bit_cnt_reg <= 4'h0;
      shift_reg   <= 8'h00;
    end
    else if (scl_rise && (bit_cnt_reg < `DCD_BIT_ACK))
    begin
      if (bit_cnt_reg < `DCD_BIT_BYTE)
      begin
        shift_reg <= {shift_reg[6:0], i_sda};
      end
      bit_cnt_reg <= bit_cnt_reg + 4'h1;
    end
    else if (ack_end)
    begin
      bit_cnt_reg <= 4'h0;
    end
  end

  // Byte decode at the end of its eighth bit
  always_comb
  begin
    byte_ack  = 1'b0;
    byte_last = 1'b0;
    byte_op   = op_reg;
    case (state_reg)
      dcd_pkg::ST_ADDR:
      begin
        byte_ack = (shift_reg == `DCD_GC_ADDR) || addr_match;
      end
      dcd_pkg::ST_WDATA:
      begin
        if (byte_idx_reg == 2'h0)
        begin
          byte_op   = decode_op(shift_reg[`DCD_B0_CMD]);
          byte_ack  = (byte_op != dcd_pkg::OP_NONE) &&
                      !((byte_op == dcd_pkg::OP_ALL) && (nvm_busy || !push_if.ready));
          byte_last = (byte_op == dcd_pkg::OP_CFG);
        end
        else
        begin
          byte_ack  = !((op_reg == dcd_pkg::OP_ALL) && !push_if.ready);
          byte_last = ((byte_idx_reg == 2'h1) && (op_reg == dcd_pkg::OP_DAC)) || (byte_idx_reg == 2'h2);
        end
      end
      dcd_pkg::ST_GCALL:
      begin
        if (!gc_done_reg)
        begin
          if (shift_reg == `DCD_GC_RESET)
          begin
            byte_op = dcd_pkg::OP_GCRST;
          end
          else if (shift_reg == `DCD_GC_WAKE)
          begin
            byte_op = dcd_pkg::OP_GCWAKE;
          end
          else
          begin
            byte_op = dcd_pkg::OP_NONE;
          end
          byte_ack  = (byte_op != dcd_pkg::OP_NONE) && !nvm_busy;
          byte_last = byte_ack;
        end
      end
      default:
      begin
        byte_ack = 1'b0;
      end
    endcase
  end

  // Command sequencing
  always_ff @(posedge i_clk)
  begin
    if (i_srst || stop_det)
    begin
      state_reg       <= dcd_pkg::ST_IDLE;
      op_reg          <= dcd_pkg::OP_NONE;
      byte_idx_reg    <= 2'h0;
      commit_pend_reg <= 1'b0;
      gc_done_reg     <= 1'b0;
    end
    else if (start_det)
    begin
      state_reg       <= dcd_pkg::ST_ADDR;
      byte_idx_reg    <= 2'h0;
      commit_pend_reg <= 1'b0;
      gc_done_reg     <= 1'b0;
    end
    else if (byte_end)
    begin
      case (state_reg)
        dcd_pkg::ST_ADDR:
        begin
          if (!byte_ack)
          begin
            state_reg <= dcd_pkg::ST_IGNORE;
          end
          else if (shift_reg == `DCD_GC_ADDR)
          begin
            state_reg <= dcd_pkg::ST_GCALL;
          end
          else if (shift_reg[0])
          begin
            state_reg <= dcd_pkg::ST_RDATA;
          end
          else
          begin
            state_reg <= dcd_pkg::ST_WDATA;
          end
        end
        dcd_pkg::ST_WDATA:
        begin
          if (!byte_ack)
          begin
            state_reg <= dcd_pkg::ST_IGNORE;
          end
          else
          begin
            op_reg          <= byte_op;
            commit_pend_reg <= byte_last;
            byte_idx_reg    <= byte_last ? 2'h0 : byte_idx_reg + 2'h1;
          end
        end
        dcd_pkg::ST_GCALL:
        begin
          if (!byte_ack)
          begin
            state_reg <= dcd_pkg::ST_IGNORE;
          end
          else
          begin
            op_reg          <= byte_op;
            commit_pend_reg <= 1'b1;
            gc_done_reg     <= 1'b1;
          end
        end
        default:
        begin
          state_reg <= state_reg;
        end
      endcase
    end
    else if (ack_end)
    begin
      commit_pend_reg <= 1'b0;
    end
    else if (scl_rise && (bit_cnt_reg == `DCD_BIT_BYTE) && (state_reg == dcd_pkg::ST_RDATA) && i_sda)
    begin
      state_reg <= dcd_pkg::ST_IGNORE;
    end
  end

  // Received byte capture
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      b0_reg <= 8'h00;
      b1_reg <= 8'h00;
      b2_reg <= 8'h00;
    end
    else if (byte_end && (state_reg == dcd_pkg::ST_WDATA))
    begin
      case (byte_idx_reg)
        2'h0:    b0_reg <= shift_reg;
        2'h1:    b1_reg <= shift_reg;
        default: b2_reg <= shift_reg;
      endcase
    end
  end

  // Read stream byte selection
  always_comb
  begin
    tx_byte = 8'h00;
    case (rd_idx_reg)
      3'h0:    tx_byte = {i_nvm_idle_flag, 2'b00, cfg_reg};
      3'h1:    tx_byte = i_fmt_8bit ? dac_reg[7:0] : dac_reg[11:4];
      3'h2:    tx_byte = i_fmt_8bit ? {i_nvm_idle_flag, 2'b00, i_nvm_cfg} : {dac_reg[3:0], 4'h0};
      3'h3:    tx_byte = i_fmt_8bit ? i_nvm_dac[7:0] : {i_nvm_idle_flag, 2'b00, i_nvm_cfg};
      3'h4:    tx_byte = i_nvm_dac[11:4];
      3'h5:    tx_byte = {i_nvm_dac[3:0], 4'h0};
      default: tx_byte = 8'h00;
    endcase
  end

  // Data line drive: acknowledge and read bits
  always_ff @(posedge i_clk)
  begin
    if (i_srst || start_det || stop_det)
    begin
      drive_reg  <= 1'b0;
      tx_reg     <= 8'h00;
      rd_idx_reg <= 3'h0;
    end
    else if (scl_fall)
    begin
      if (bit_cnt_reg == `DCD_BIT_BYTE)
      begin
        drive_reg <= byte_ack;
      end
      else if (bit_cnt_reg == `DCD_BIT_ACK)
      begin
        drive_reg <= (state_reg == dcd_pkg::ST_RDATA) && !tx_byte[7];
        if (state_reg == dcd_pkg::ST_RDATA)
        begin
          tx_reg     <= tx_byte;
          rd_idx_reg <= (rd_idx_reg == rd_last) ? 3'h0 : rd_idx_reg + 3'h1;
        end
      end
      else if ((state_reg == dcd_pkg::ST_RDATA) && (bit_cnt_reg != 4'h0))
      begin
        drive_reg <= !tx_reg[3'h7 - bit_cnt_reg[2:0]];
      end
    end
  end

  assign o_sda_o  = 1'b0;
  assign o_sda_oe = drive_reg;

  // Volatile registers, loaded from nonvolatile after reset, otherwise updated at the acknowledge falling edge
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      dac_reg      <= `DCD_RST_DAC;
      cfg_reg      <= `DCD_RST_CFG;
      por_load_reg <= 1'b1;
    end
    else if (por_load_reg)
    begin
      dac_reg      <= i_nvm_dac;
      cfg_reg      <= i_nvm_cfg;
      por_load_reg <= 1'b0;
    end
    else if (commit)
    begin
      case (op_reg)
        dcd_pkg::OP_DAC:
        begin
          dac_reg              <= dac_cmd_word;
          cfg_reg[`DCD_CFG_PD] <= b0_reg[`DCD_B0_PD];
        end
        dcd_pkg::OP_VOL, dcd_pkg::OP_ALL:
        begin
          dac_reg <= vol_cmd_word;
          cfg_reg <= b0_reg[`DCD_B0_CFG];
        end
        dcd_pkg::OP_CFG:
        begin
          cfg_reg <= b0_reg[`DCD_B0_CFG];
        end
        dcd_pkg::OP_GCWAKE:
        begin
          cfg_reg[`DCD_CFG_PD] <= `DCD_PD_ACTIVE;
        end
        dcd_pkg::OP_GCRST:
        begin
          por_load_reg <= 1'b1;
        end
        default:
        begin
          cfg_reg <= cfg_reg;
        end
      endcase
    end
  end

  assign o_dac_value             = dac_reg;
  assign o_vref_sel              = cfg_reg[`DCD_CFG_VREF];
  assign o_powerdown_select_bits = cfg_reg[`DCD_CFG_PD];
  assign o_gain_sel              = cfg_reg[`DCD_CFG_GAIN];
  assign o_reload_pulse          = por_load_reg;

  // Nonvolatile write queue, only the all-memory command feeds it
  assign push_if.valid = commit && (op_reg == dcd_pkg::OP_ALL);
  assign push_if.data  = {b0_reg[`DCD_B0_CFG], vol_cmd_word};
  assign pop_if.ready  = i_nvm_wr_ready;
  assign o_nvm_wr_valid = pop_if.valid;
  assign o_nvm_wr_data  = pop_if.data;

  dcd_fifo #(
    .W     (`DCD_NVM_W),
    .DEPTH (`DCD_FIFO_DEPTH)
  ) u_nvm_fifo (
    .i_clk  (i_clk),
    .i_srst (i_srst),
    .s_in   (push_if),
    .m_out  (pop_if)
  );

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst);

  chk_stop_to_idle: assert property (stop_det |=> state_reg == dcd_pkg::ST_IDLE)
    else $error("stop did not return to idle");
  chk_gc_extra_nack: assert property ((state_reg == dcd_pkg::ST_GCALL) && gc_done_reg && byte_end
    |=> !o_sda_oe && (state_reg == dcd_pkg::ST_IGNORE))
    else $error("extra general call byte acknowledged");
  chk_abort_no_write: assert property ((start_det || stop_det) |=> $stable(dac_reg) && $stable(cfg_reg))
    else $error("abort changed volatile contents");
  chk_dac_cmd_load: assert property (commit && (op_reg == dcd_pkg::OP_DAC)
    |=> (dac_reg == $past(dac_cmd_word)) && $stable(o_vref_sel) && $stable(o_gain_sel))
    else $error("dac command load wrong");
  chk_dac_no_nvm: assert property (commit && (op_reg == dcd_pkg::OP_DAC) |-> !push_if.valid)
    else $error("dac command reached nonvolatile queue");
  chk_cfg_keeps_dac: assert property (commit && (op_reg == dcd_pkg::OP_CFG) |=> $stable(dac_reg))
    else $error("configuration command changed dac");
  chk_wake_clears_pd: assert property (commit && (op_reg == dcd_pkg::OP_GCWAKE)
    |=> (o_powerdown_select_bits == `DCD_PD_ACTIVE) && $stable(dac_reg))
    else $error("wake did not clear power-down");
  chk_reset_reload: assert property (commit && (op_reg == dcd_pkg::OP_GCRST)
    |=> o_reload_pulse ##1 (dac_reg == $past(i_nvm_dac)) && (cfg_reg == $past(i_nvm_cfg)))
    else $error("general call reset did not reload");
  chk_bad_addr_nack: assert property ((state_reg == dcd_pkg::ST_ADDR) && byte_end && !byte_ack
    |=> !o_sda_oe [*2])
    else $error("foreign address acknowledged");
  chk_reserved_code: assert property ((state_reg == dcd_pkg::ST_WDATA) && (byte_idx_reg == 2'h0) && byte_end
    && (decode_op(shift_reg[7:5]) == dcd_pkg::OP_NONE) |=> !o_sda_oe && (state_reg == dcd_pkg::ST_IGNORE))
    else $error("reserved code accepted");
  chk_all_pushes: assert property (commit && (op_reg == dcd_pkg::OP_ALL) |-> push_if.valid && push_if.ready)
    else $error("all-memory write not queued");
  chk_busy_refuse: assert property ((state_reg == dcd_pkg::ST_WDATA) && (byte_idx_reg == 2'h0) && byte_end
    && (decode_op(shift_reg[7:5]) == dcd_pkg::OP_ALL) && nvm_busy |=> !o_sda_oe)
    else $error("write accepted while nonvolatile busy");
endmodule
`default_nettype wire

// file: common/dcd_cfg.svh
`ifndef DCD_CFG_SVH
`define DCD_CFG_SVH

// Bus addressing
`define DCD_ADDR_PREFIX   4'hC
`define DCD_GC_ADDR       8'h00
`define DCD_GC_RESET      8'h06
`define DCD_GC_WAKE       8'h09

// Write op codes in the top bits of the command byte
`define DCD_CMD_VOL       3'h2
`define DCD_CMD_ALL       3'h3
`define DCD_CMD_CFG       3'h4
`define DCD_CMD_DAC_HI    2'h0

// Command byte fields
`define DCD_B0_CMD        7:5
`define DCD_B0_CMD2       7:6
`define DCD_B0_PD         5:4
`define DCD_B0_DACHI      3:0
`define DCD_B0_CFG        4:0
`define DCD_B2_DACLO      7:4

// Volatile configuration fields
`define DCD_CFG_VREF      4:3
`define DCD_CFG_PD        2:1
`define DCD_CFG_GAIN      0

// Reset values
`define DCD_RST_DAC       12'h000
`define DCD_RST_CFG       5'h00
`define DCD_PD_ACTIVE     2'h0

// Bit slot counts
`define DCD_BIT_BYTE      4'h8
`define DCD_BIT_ACK       4'h9

// Read stream
`define DCD_RD_LAST12     3'h5
`define DCD_RD_LAST8      3'h3

// Nonvolatile write queue
`define DCD_NVM_W         17
`define DCD_FIFO_DEPTH    32

`endif

// file: common/dcd_pkg.sv
`default_nettype none
package dcd_pkg;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_WDATA,
    ST_RDATA,
    ST_GCALL,
    ST_IGNORE
  } dcd_state_e;

  typedef enum logic [2:0] {
    OP_NONE,
    OP_DAC,
    OP_VOL,
    OP_ALL,
    OP_CFG,
    OP_GCRST,
    OP_GCWAKE
  } dcd_op_e;

endpackage
`default_nettype wire

// file: common/dcd_stream_if.sv
`timescale 1ns/1ns
`default_nettype none
interface dcd_stream_if #(
  parameter int W = 8
);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;

  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// file: logic/dcd_fifo.sv
`timescale 1ns/1ns
`default_nettype none
module dcd_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 32
) (
  input  wire logic  i_clk,
  input  wire logic  i_srst,
  dcd_stream_if.snk  s_in,
  dcd_stream_if.src  m_out
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0]  mem [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0]   count_reg;
  logic          push;
  logic          pop;

  assign s_in.ready  = (count_reg != (AW+1)'(DEPTH));
  assign m_out.valid = (count_reg != '0);
  assign m_out.data  = mem[rd_ptr_reg];
  assign push        = s_in.valid && s_in.ready;
  assign pop         = m_out.valid && m_out.ready;

  // Storage
  always_ff @(posedge i_clk)
  begin
    if (push)
    begin
      mem[wr_ptr_reg] <= s_in.data;
    end
  end

  // Pointers and fill level
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (pop)
      begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
      case ({push, pop})
        2'b10:   count_reg <= count_reg + 1'b1;
        2'b01:   count_reg <= count_reg - 1'b1;
        default: count_reg <= count_reg;
      endcase
    end
  end
endmodule
`default_nettype wire

// file: tb/dcd_master.sv
`timescale 1ns/1ns
`default_nettype none
module dcd_master (
  input  wire logic i_clk,
  input  wire logic i_sda_oe,
  output logic      o_scl,
  output logic      o_sda
);
  logic sd = 1'b1;
  // Pulled-up wire, low while either side pulls
  assign o_sda = sd & ~i_sda_oe;
  initial o_scl = 1'b1;
  task automatic hp();
    repeat (4) @(posedge i_clk);
    #1;
  endtask
  task automatic clk9(input logic b, output logic s);
    sd = b;
    hp();
    o_scl = 1'b1;
    hp();
    s = o_sda;
    o_scl = 1'b0;
    hp();
  endtask
  task automatic start();
    sd = 1'b1;
    hp();
    o_scl = 1'b1;
    hp();
    sd = 1'b0;
    hp();
    o_scl = 1'b0;
    hp();
  endtask
  task automatic stop();
    sd = 1'b0;
    hp();
    o_scl = 1'b1;
    hp();
    sd = 1'b1;
    hp();
  endtask
  task automatic bits(input logic [7:0] v, input int n);
    logic s;
    for (int i = 0; i < n; i++)
      clk9(v[7 - i], s);
  endtask
  // Eight data clocks plus one acknowledge clock
  task automatic wbyte(input logic [7:0] v, output logic ack);
    bits(v, 8);
    clk9(1'b1, ack);
    ack = ~ack;
  endtask
  task automatic rbyte(input logic nack, output logic [7:0] v);
    logic s;
    for (int i = 0; i < 8; i++)
      clk9(1'b1, v[7 - i]);
    clk9(nack, s);
  endtask
endmodule
`default_nettype wire

// file: tb/testbench.sv
`timescale 1ns/1ns
`default_nettype none
`include "dcd_cfg.svh"
module testbench;
  logic                  clk = 1'b0;
  logic                  srst = 1'b1;
  logic                  scl;
  logic                  sda;
  logic                  oe;
  logic [2:0]            asel;
  logic                  fmt = 1'b0;
  logic                  idle = 1'b1;
  logic [11:0]           ndac;
  logic [4:0]            ncfg;
  logic [11:0]           dac;
  logic [1:0]            vref;
  logic [1:0]            pd;
  logic                  gain;
  logic                  wv;
  logic                  rdy = 1'b0;
  logic [`DCD_NVM_W-1:0] wd;
  logic [31:0]           seed = 32'h6f71_0af2;
  int                    n_fail = 0;
  int                    comparisons = 0;
  int                    cyc = 0;
  int                    n_rl = 0;
  logic                  rl;
  int                    m_dac;
  int                    m_cfg;
  int                    nq[$];
  logic                  ak;
  logic [7:0]            rb;
  logic [16:0]           v;

  dcd_decoder i_dcd_decoder (
    .i_clk(clk), .i_srst(srst), .i_scl(scl), .i_sda(sda), .o_sda_o(), .o_sda_oe(oe),
    .i_addr_sel(asel), .i_fmt_8bit(fmt), .i_nvm_idle_flag(idle), .i_nvm_dac(ndac),
    .i_nvm_cfg(ncfg), .o_dac_value(dac), .o_vref_sel(vref), .o_powerdown_select_bits(pd),
    .o_gain_sel(gain), .o_reload_pulse(rl), .o_nvm_wr_valid(wv), .i_nvm_wr_ready(rdy),
    .o_nvm_wr_data(wd)
  );
  dcd_master i_dcd_master (.i_clk(clk), .i_sda_oe(oe), .o_scl(scl), .o_sda(sda));

  always #2 clk = ~clk;
  always @(posedge clk)
  begin
    cyc++;
    if (!srst && rl === 1'b1)
      n_rl++;
    if (cyc == 60000)
    begin
      n_fail++;
      results();
    end
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e)
    begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic cmp_out();
    chk({15'h0, vref, pd, gain, dac}, {15'h0, m_cfg[4:0], m_dac[11:0]});
  endtask
  task automatic cmp_ack(input logic e);
    chk({31'h0, ak}, {31'h0, e});
  endtask
  task automatic cmp_word(input logic [16:0] g, input logic [16:0] e);
    chk({15'h0, g}, {15'h0, e});
  endtask
  task automatic wr(input logic [7:0] b, input logic e);
    i_dcd_master.wbyte(b, ak);
    cmp_ack(e);
  endtask
  task automatic go(input logic rw);
    i_dcd_master.start();
    wr({4'hC, asel, rw}, 1'b1);
  endtask
  task automatic w2(input logic [1:0] p, input logic [11:0] d);
    wr({2'b00, p, d[11:8]}, 1'b1);
    wr(d[7:0], 1'b1);
    m_dac = d;
    m_cfg[2:1] = p;
  endtask
  task automatic w3(input logic [2:0] op, input logic [16:0] x, input logic e);
    wr({op, x[16:12]}, e);
    if (e && op != 3'h4)
    begin
      wr(x[11:4], 1'b1);
      wr({x[3:0], 4'h0}, 1'b1);
      m_dac = x[11:0];
    end
    if (e)
      m_cfg = x[16:12];
    if (e && op == 3'h3)
      nq.push_back(x);
  endtask
  task automatic results();
    $display("TB: checks=%0d failures=%0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  initial
  begin
    v = 17'(rnd());
    {ncfg, ndac} = v;
    asel = 3'(rnd());
    repeat (3) @(posedge clk);
    #1;
    srst = 1'b0;
    m_dac = ndac;
    m_cfg = ncfg;
    repeat (3) @(posedge clk);
    #1;
    cmp_out();
    go(1'b0);
    for (int i = 0; i < 4; i++)
    begin
      w2(2'(3 - i), 12'(rnd()));
      cmp_out();
    end
    i_dcd_master.stop();
    cmp_out();
    go(1'b0);
    for (int i = 0; i < 3; i++)
    begin
      w3(i == 0 ? 3'h2 : (i == 1 ? 3'h4 : 3'h3), 17'(rnd()) | 17'h0_2000, 1'b1);
      cmp_out();
    end
    i_dcd_master.stop();
    cmp_word(wd, 17'(nq[0]));
    i_dcd_master.start();
    wr(8'h00, 1'b1);
    wr(8'h09, 1'b1);
    wr(8'h06, 1'b0);
    i_dcd_master.stop();
    m_cfg[2:1] = 2'b00;
    cmp_out();
    for (int op = 5; op < 8; op++)
    begin
      go(1'b0);
      w3(3'(op), 17'(rnd()), 1'b0);
      i_dcd_master.stop();
      cmp_out();
    end
    for (int j = 0; j < 2; j++)
    begin
      i_dcd_master.start();
      wr(j == 0 ? {4'hC, asel ^ 3'h1, 1'b0} : {4'hD, asel, 1'b0}, 1'b0);
      wr(8'h00, 1'b0);
      i_dcd_master.stop();
      go(1'b0);
      wr({2'b00, ~m_cfg[2:1], ~m_dac[11:8]}, 1'b1);
      i_dcd_master.bits(8'hA5, 4);
      if (j == 0)
        i_dcd_master.stop();
      else
      begin
        i_dcd_master.start();
        i_dcd_master.stop();
      end
      cmp_out();
    end
    idle = 1'b0;
    go(1'b0);
    w3(3'h3, 17'(rnd()), 1'b0);
    i_dcd_master.start();
    i_dcd_master.wbyte(8'h00, ak);
    wr(8'h06, 1'b0);
    go(1'b0);
    w2(2'b01, 12'(rnd()));
    i_dcd_master.stop();
    cmp_out();
    idle = 1'b1;
    {ncfg, ndac} = 17'(rnd());
    i_dcd_master.start();
    wr(8'h00, 1'b1);
    wr(8'h06, 1'b1);
    i_dcd_master.stop();
    m_dac = ndac;
    m_cfg = ncfg;
    cmp_out();
    go(1'b1);
    i_dcd_master.rbyte(1'b0, rb);
    cmp_word({9'h0, rb}, {9'h0, idle, 2'b00, m_cfg[4:0]});
    i_dcd_master.rbyte(1'b0, rb);
    cmp_word({9'h0, rb}, {9'h0, m_dac[11:4]});
    i_dcd_master.rbyte(1'b1, rb);
    cmp_word({9'h0, rb}, {9'h0, m_dac[3:0], 4'h0});
    i_dcd_master.stop();
    fmt = 1'b1;
    go(1'b1);
    i_dcd_master.rbyte(1'b0, rb);
    i_dcd_master.rbyte(1'b1, rb);
    cmp_word({9'h0, rb}, {9'h0, m_dac[7:0]});
    i_dcd_master.stop();
    go(1'b0);
    while (nq.size() < 32)
      w3(3'h3, 17'(rnd()), 1'b1);
    w3(3'h3, 17'(rnd()), 1'b0);
    i_dcd_master.stop();
    cmp_out();
    repeat (400)
    begin
      if (wv === 1'b1 && rdy && nq.size() > 0)
        cmp_word(wd, 17'(nq.pop_front()));
      @(posedge clk);
      #1;
      rdy = 1'(rnd() & 32'h0000_0001);
    end
    rdy = 1'b0;
    cmp_word({16'h0, wv}, 17'(nq.size()));
    cmp_word(17'(n_rl), 17'h2);
    results();
  end
endmodule
`default_nettype wire
